// >>> hdl/fea_defs.svh
// Register offsets, field positions, reset values and timing counts of the fine edge block
`ifndef FEA_DEFS_SVH
`define FEA_DEFS_SVH

// Register word offsets on the plain register port
`define FEA_ADDR_W          8
`define FEA_OFS_CONFIG      8'h00
`define FEA_OFS_PRD_CTRL    8'h01
`define FEA_OFS_PRD_COARSE  8'h02
`define FEA_OFS_PRD_FINE    8'h03
`define FEA_OFS_COMPARE_A_COARSE_COARSE 8'h04
`define FEA_OFS_COMPARE_A_COARSE_FINE   8'h05
`define FEA_OFS_PHASE_FINE  8'h06
`define FEA_OFS_SCALE       8'h07
`define FEA_OFS_UNLOCK      8'h08
`define FEA_OFS_FORCE_SYNC  8'h09
`define FEA_OFS_INT_STATUS  8'h0A
`define FEA_OFS_INT_CLEAR   8'h0B
`define FEA_OFS_INT_ENABLE  8'h0C
`define FEA_OFS_CAL_STATUS  8'h0D

// Field positions
`define FEA_CFG_HR_ENABLE   0
`define FEA_CFG_AUTO_CONV   1
`define FEA_PCTL_FINE_PRD   0
`define FEA_PCTL_PHASE_LOAD 2
`define FEA_FINE_MSB        15
`define FEA_FINE_LSB        8
`define FEA_INT_PRD_START   0
`define FEA_INT_CAL_DONE    1
`define FEA_INT_CAL_ERROR   2
`define FEA_INT_PHASE_SYNC  3
`define FEA_INT_W           4

// Values
`define FEA_UNLOCK_KEY      16'hA5A5
`define FEA_SCALE_RST       8'h00
`define FEA_SCALE_MAX       9'h0FF
`define FEA_ROUND_HALF      16'h0080
`define FEA_PRD_RST         16'hFFFF

// Guard band at the head of every period and, with fine period on, at its tail, in system clock cycles
`define FEA_GUARD_CYC       16'h0003

`endif

// >>> hdl/fea_pkg.sv
// Types shared by the fine edge autoscale block
package fea_pkg;

  // Control bits gathered from the configuration registers
  typedef struct packed {
    logic hr_enable;
    logic auto_convert_enable;
    logic fine_period_enable;
    logic phase_load_enable;
  } fea_ctrl_s;

  // Micro-step delays handed to the edge positioner
  typedef struct packed {
    logic       active;
    logic [7:0] duty_steps;
    logic [7:0] period_steps;
    logic [7:0] phase_steps;
  } fea_fine_s;

  // Count-position states of the period
  typedef enum logic [2:0] {
    FEA_GUARD_HEAD = 3'b001,
    FEA_OPEN       = 3'b010,
    FEA_GUARD_TAIL = 3'b100
  } fea_zone_e;

endpackage

// >>> hdl/fea_scale_conv.sv
// Fraction to micro-step converter for one fine register
`timescale 1ns/10ps
`default_nettype none
`include "fea_defs.svh"

module fea_scale_conv
  import fea_pkg::*;
(
  input  wire logic        auto_convert_enable,
  input  wire logic [15:0] fine_value,
  input  wire logic [7:0]  scale,
  output logic      [7:0]  steps
);

  logic [15:0] product;

  // Scaled fraction with half-step rounding, or the raw count
  always_comb
  begin
    // Widen before the multiply so the full 16-bit product survives
    product = 16'(fine_value[`FEA_FINE_MSB:`FEA_FINE_LSB]) * 16'(scale) + `FEA_ROUND_HALF;
    if (auto_convert_enable)
    begin
      steps = product[15:8];
    end
    else
    begin
      steps = fine_value[`FEA_FINE_MSB:`FEA_FINE_LSB];
    end
  end

endmodule
`default_nettype wire

// >>> hdl/fea_top.sv
// Fine edge autoscale PWM block: registers, calibration capture, guard zones and fine edge delays
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "fea_defs.svh"

module fea_top
  import fea_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  input  wire logic [`FEA_ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [15:0]            reg_rdata,
  input  wire logic                   cal_done,
  input  wire logic [8:0]             cal_steps,
  input  wire logic                   sync_in,
  input  wire logic                   compare_sync,
  output logic                        pwm_out,
  output fea_fine_s                   fine_out,
  output logic                        irq
);

  fea_ctrl_s                 ctrl_r;
  logic      [15:0]          period_coarse_r;
  logic      [15:0]          period_fine_r;
  logic      [15:0]          compare_a_coarse_r;
  logic      [15:0]          compare_a_fine_r;
  logic      [15:0]          phase_fine_r;
  logic      [7:0]           fine_step_scale_reg_r;
  logic                      unlock_r;
  logic      [8:0]           cal_last_r;
  logic                      cal_error_r;
  logic      [15:0]          cnt_r;
  logic      [`FEA_INT_W-1:0] int_status_r;
  logic      [`FEA_INT_W-1:0] int_enable_r;
  logic      [`FEA_INT_W-1:0] int_event;
  logic      [15:0]          reg_rdata_r;
  logic                      pwm_out_r;
  fea_fine_s                 fine_out_r;
  fea_zone_e                 zone;
  logic                      force_sync;
  logic                      phase_event;
  logic                      period_start;
  logic                      cal_ok;
  logic                      cal_bad;
  logic      [7:0]           duty_steps;
  logic      [7:0]           period_steps;
  logic      [7:0]           phase_steps;

  // Write decode helper, shared by the protected, unlock, clear and force-sync writes
  function automatic logic hit(input logic [`FEA_ADDR_W-1:0] ofs);
    hit = reg_wr && (reg_addr == ofs);
  endfunction

  // One converter module, instanced for compare, period and phase, keeps the arithmetic in one place
  fea_scale_conv u_conv_duty
  (
    .auto_convert_enable (ctrl_r.auto_convert_enable),
    .fine_value          (compare_a_fine_r),
    .scale               (fine_step_scale_reg_r),
    .steps               (duty_steps)
  );

  fea_scale_conv u_conv_period
  (
    .auto_convert_enable (ctrl_r.auto_convert_enable),
    .fine_value          (period_fine_r),
    .scale               (fine_step_scale_reg_r),
    .steps               (period_steps)
  );

  fea_scale_conv u_conv_phase
  (
    .auto_convert_enable (ctrl_r.auto_convert_enable),
    .fine_value          (phase_fine_r),
    .scale               (fine_step_scale_reg_r),
    .steps               (phase_steps)
  );

  // Event strobes
  assign force_sync   = hit(`FEA_OFS_FORCE_SYNC) && reg_wdata[0];
  assign phase_event  = ctrl_r.phase_load_enable && (sync_in || compare_sync || force_sync);
  assign period_start = (cnt_r == 16'h0000);
  assign cal_ok       = cal_done && (cal_steps != 9'h000) && (cal_steps <= `FEA_SCALE_MAX);
  assign cal_bad      = cal_done && (cal_steps > `FEA_SCALE_MAX);

  // Protected-write unlock: key opens, any other value closes
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      unlock_r <= 1'b0;
    end
    else if (hit(`FEA_OFS_UNLOCK))
    begin
      unlock_r <= (reg_wdata == `FEA_UNLOCK_KEY);
    end
  end

  // Protected configuration registers
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_r <= '0;
    end
    else if (unlock_r)
    begin
      if (hit(`FEA_OFS_CONFIG))
      begin
        ctrl_r.hr_enable           <= reg_wdata[`FEA_CFG_HR_ENABLE];
        ctrl_r.auto_convert_enable <= reg_wdata[`FEA_CFG_AUTO_CONV];
      end
      else if (hit(`FEA_OFS_PRD_CTRL))
      begin
        ctrl_r.fine_period_enable  <= reg_wdata[`FEA_PCTL_FINE_PRD];
        ctrl_r.phase_load_enable   <= reg_wdata[`FEA_PCTL_PHASE_LOAD];
      end
    end
  end

  // Plain value registers
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      period_coarse_r    <= `FEA_PRD_RST;
      period_fine_r      <= 16'h0000;
      compare_a_coarse_r <= 16'h0000;
      compare_a_fine_r   <= 16'h0000;
      phase_fine_r       <= 16'h0000;
      int_enable_r       <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `FEA_OFS_PRD_COARSE)
      begin
        period_coarse_r <= reg_wdata;
      end
      else if (reg_addr == `FEA_OFS_PRD_FINE)
      begin
        period_fine_r <= {reg_wdata[15:8], 8'h00};
      end
      else if (reg_addr == `FEA_OFS_COMPARE_A_COARSE_COARSE)
      begin
        compare_a_coarse_r <= reg_wdata;
      end
      else if (reg_addr == `FEA_OFS_COMPARE_A_COARSE_FINE)
      begin
        compare_a_fine_r <= {reg_wdata[15:8], 8'h00};
      end
      else if (reg_addr == `FEA_OFS_PHASE_FINE)
      begin
        phase_fine_r <= {reg_wdata[15:8], 8'h00};
      end
      else if (reg_addr == `FEA_OFS_INT_ENABLE)
      begin
        int_enable_r <= reg_wdata[`FEA_INT_W-1:0];
      end
    end
  end

  // Scale factor: a nonzero calibration result wins over a software write in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fine_step_scale_reg_r <= `FEA_SCALE_RST;
    end
    else if (cal_ok)
    begin
      fine_step_scale_reg_r <= cal_steps[7:0];
    end
    else if (cal_bad)
    begin
      fine_step_scale_reg_r <= fine_step_scale_reg_r;
    end
    else if (unlock_r && hit(`FEA_OFS_SCALE) && (reg_wdata[7:0] != 8'h00))
    begin
      fine_step_scale_reg_r <= reg_wdata[7:0];
    end
  end

  // Last calibration measurement and its error flag
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cal_last_r  <= 9'h000;
      cal_error_r <= 1'b0;
    end
    else if (cal_done)
    begin
      cal_last_r  <= cal_steps;
      cal_error_r <= cal_bad;
    end
  end

  // Coarse period counter, up count from zero to the period value
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_r <= 16'h0000;
    end
    else if (cnt_r >= period_coarse_r)
    begin
      cnt_r <= 16'h0000;
    end
    else
    begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // Zone of the count; period below 6 leaves no open zone with fine period on
  always_comb
  begin
    if (cnt_r < `FEA_GUARD_CYC)
    begin
      zone = FEA_GUARD_HEAD;
    end
    else if (ctrl_r.fine_period_enable && (32'(cnt_r) + 32'(`FEA_GUARD_CYC) > 32'(period_coarse_r)))
    begin
      zone = FEA_GUARD_TAIL;
    end
    else
    begin
      zone = FEA_OPEN;
    end
  end

  // Coarse PWM output, high while the count is below compare-A
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pwm_out_r <= 1'b0;
    end
    else
    begin
      pwm_out_r <= (cnt_r < compare_a_coarse_r);
    end
  end

  // Fine edge delays; held at zero inside the guard zones
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fine_out_r.active       <= 1'b0;
      fine_out_r.duty_steps   <= 8'h00;
      fine_out_r.period_steps <= 8'h00;
    end
    else
    begin
      case (zone)
        FEA_OPEN:
        begin
          fine_out_r.active       <= ctrl_r.hr_enable;
          fine_out_r.duty_steps   <= ctrl_r.hr_enable ? duty_steps : 8'h00;
          fine_out_r.period_steps <= (ctrl_r.hr_enable && ctrl_r.fine_period_enable) ? period_steps : 8'h00;
        end
        default:
        begin
          fine_out_r.active       <= 1'b0;
          fine_out_r.duty_steps   <= 8'h00;
          fine_out_r.period_steps <= 8'h00;
        end
      endcase
    end
  end

  // Fine phase only moves on a sync event, so channels align on the same edge
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fine_out_r.phase_steps <= 8'h00;
    end
    else if (phase_event)
    begin
      fine_out_r.phase_steps <= phase_steps;
    end
  end

  // Sticky interrupt status; a new event beats a clear in the same cycle
  assign int_event = {phase_event, cal_bad, cal_ok, period_start};

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      int_status_r <= '0;
    end
    else if (hit(`FEA_OFS_INT_CLEAR))
    begin
      int_status_r <= (int_status_r & ~reg_wdata[`FEA_INT_W-1:0]) | int_event;
    end
    else
    begin
      int_status_r <= int_status_r | int_event;
    end
  end

  // Read data, valid the cycle after the strobe only
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata_r <= 16'h0000;
    end
    else if (!reg_rd)
    begin
      reg_rdata_r <= 16'h0000;
    end
    else if (reg_addr == `FEA_OFS_CONFIG)
    begin
      reg_rdata_r <= {14'h0000, ctrl_r.auto_convert_enable, ctrl_r.hr_enable};
    end
    else if (reg_addr == `FEA_OFS_PRD_CTRL)
    begin
      reg_rdata_r <= {13'h0000, ctrl_r.phase_load_enable, 1'b0, ctrl_r.fine_period_enable};
    end
    else if (reg_addr == `FEA_OFS_PRD_COARSE)
    begin
      reg_rdata_r <= period_coarse_r;
    end
    else if (reg_addr == `FEA_OFS_PRD_FINE)
    begin
      reg_rdata_r <= period_fine_r;
    end
    else if (reg_addr == `FEA_OFS_COMPARE_A_COARSE_COARSE)
    begin
      reg_rdata_r <= compare_a_coarse_r;
    end
    else if (reg_addr == `FEA_OFS_COMPARE_A_COARSE_FINE)
    begin
      reg_rdata_r <= compare_a_fine_r;
    end
    else if (reg_addr == `FEA_OFS_PHASE_FINE)
    begin
      reg_rdata_r <= phase_fine_r;
    end
    else if (reg_addr == `FEA_OFS_SCALE)
    begin
      reg_rdata_r <= {8'h00, fine_step_scale_reg_r};
    end
    else if (reg_addr == `FEA_OFS_UNLOCK)
    begin
      reg_rdata_r <= {15'h0000, unlock_r};
    end
    else if (reg_addr == `FEA_OFS_INT_STATUS)
    begin
      reg_rdata_r <= {12'h000, int_status_r};
    end
    else if (reg_addr == `FEA_OFS_INT_ENABLE)
    begin
      reg_rdata_r <= {12'h000, int_enable_r};
    end
    else if (reg_addr == `FEA_OFS_CAL_STATUS)
    begin
      reg_rdata_r <= {cal_error_r, 6'h00, cal_last_r};
    end
    else
    begin
      reg_rdata_r <= 16'h0000;
    end
  end

  // Outputs
  assign reg_rdata = reg_rdata_r;
  assign pwm_out   = pwm_out_r;
  assign fine_out  = fine_out_r;
  assign irq       = |(int_status_r & int_enable_r);

endmodule
`default_nettype wire

// >>> sim/fea_top_properties.sv
// Port-level assertions and covers for the fine edge autoscale block
`timescale 1ns/10ps
`default_nettype none
`include "fea_defs.svh"

module fea_top_properties
  import fea_pkg::*;
(
  input wire logic                   clk_sys,
  input wire logic                   reset_n,
  input wire logic [`FEA_ADDR_W-1:0] reg_addr,
  input wire logic [15:0]            reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [15:0]            reg_rdata,
  input wire logic                   cal_done,
  input wire logic [8:0]             cal_steps,
  input wire logic                   sync_in,
  input wire logic                   compare_sync,
  input wire logic                   pwm_out,
  input wire fea_fine_s              fine_out,
  input wire logic                   irq
);
  // One clock domain, so clocking and disable are shared
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // Register port answers
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  a_scale_upper: assert property (reg_rd && reg_addr == `FEA_OFS_SCALE |=> reg_rdata[15:8] == 8'h00)
    else $error("scale register upper byte not zero");
  a_fine_low_byte: assert property (reg_rd && (reg_addr == `FEA_OFS_PRD_FINE || reg_addr == `FEA_OFS_COMPARE_A_COARSE_FINE
    || reg_addr == `FEA_OFS_PHASE_FINE) |=> reg_rdata[7:0] == 8'h00)
    else $error("fine register low byte not zero");

  // Calibration capture into the scale register, seen by a read right after
  a_cal_valid_load: assert property (cal_done && cal_steps inside {[9'h001:9'h0FF]} ##1
    reg_rd && reg_addr == `FEA_OFS_SCALE |=> reg_rdata == {7'h00, $past(cal_steps, 2)})
    else $error("valid calibration result not loaded into scale");
  a_cal_error_keep: assert property (reg_rd && reg_addr == `FEA_OFS_SCALE ##1
    cal_done && (cal_steps[8] || cal_steps == 9'h000) && !reg_wr ##1
    reg_rd && reg_addr == `FEA_OFS_SCALE |=> reg_rdata == $past(reg_rdata, 2))
    else $error("scale changed by an out of range calibration result");

  // Head guard: pwm rise marks count zero, aligned with fine outputs
  a_head_guard: assert property ($rose(pwm_out) |-> !fine_out.active [*3])
    else $error("fine edge active in the first three clocks of a period");
  a_head_zero: assert property ($rose(pwm_out) |->
    (fine_out.duty_steps == 8'h00 && fine_out.period_steps == 8'h00) [*3])
    else $error("fine delays not zero in the first three clocks of a period");

  // Phase delay only moves after a sync event
  a_phase_hold: assert property (!(sync_in || compare_sync || (reg_wr && reg_addr == `FEA_OFS_FORCE_SYNC
    && reg_wdata[0])) |=> $stable(fine_out.phase_steps))
    else $error("fine phase changed without a sync event");

  c_fine_open: cover property ($rose(pwm_out) ##3 fine_out.active);
  c_cal_error: cover property (cal_done && cal_steps[8]);
  c_phase_sync: cover property ((sync_in || compare_sync) ##[1:2] $changed(fine_out.phase_steps));
endmodule

bind fea_top fea_top_properties i_props (
  .clk_sys      (clk_sys),
  .reset_n      (reset_n),
  .reg_addr     (reg_addr),
  .reg_wdata    (reg_wdata),
  .reg_wr       (reg_wr),
  .reg_rd       (reg_rd),
  .reg_rdata    (reg_rdata),
  .cal_done     (cal_done),
  .cal_steps    (cal_steps),
  .sync_in      (sync_in),
  .compare_sync (compare_sync),
  .pwm_out      (pwm_out),
  .fine_out     (fine_out),
  .irq          (irq)
);
`default_nettype wire

// >>> sim/test_fea_top.sv
// Self-checking testbench for the fine edge autoscale block
`timescale 1ns/10ps
`default_nettype none
`include "fea_defs.svh"

module test_fea_top
  import fea_pkg::*;
;
  logic        clk_sys      = 1'b0;
  logic        reset_n      = 1'b0;
  logic [7:0]  reg_addr     = 8'h00;
  logic [15:0] reg_wdata    = 16'h0000;
  logic        reg_wr       = 1'b0;
  logic        reg_rd       = 1'b0;
  logic        cal_done     = 1'b0;
  logic [8:0]  cal_steps    = 9'h000;
  logic        sync_in      = 1'b0;
  logic        compare_sync = 1'b0;
  logic [15:0] reg_rdata;
  logic        pwm_out;
  logic        irq;
  fea_fine_s   fine_out;
  int          mismatches   = 0;
  int          checks       = 0;
  logic [15:0] lfsr_r       = 16'h80BF;
  logic [7:0]  scale_r      = 8'h00;
  logic [15:0] rd_val;
  logic        au;
  logic [7:0]  rst_a [7]    = '{8'h00, 8'h01, 8'h02, 8'h07, 8'h0B, 8'h0C, 8'h0F};
  logic [15:0] rst_v [7]    = '{16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

  fea_top i_dut (
    .clk_sys      (clk_sys),
    .reset_n      (reset_n),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .cal_done     (cal_done),
    .cal_steps    (cal_steps),
    .sync_in      (sync_in),
    .compare_sync (compare_sync),
    .pwm_out      (pwm_out),
    .fine_out     (fine_out),
    .irq          (irq)
  );

  // 40 MHz system clock
  always #12.5 clk_sys = ~clk_sys;

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected micro-steps; manual mode passes the fraction through
  function automatic logic [7:0] conv(input logic [7:0] f, input logic [7:0] s, input logic a);
    logic [16:0] p;
    p = 17'(f) * 17'(s) + 17'h0_0080;
    return a ? p[15:8] : f;
  endfunction

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  // read scale, calibrate, read again back to back
  task automatic cal_rd(input logic [8:0] v);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= `FEA_OFS_SCALE;
    @(posedge clk_sys);
    reg_rd    <= 1'b0;
    cal_done  <= 1'b1;
    cal_steps <= v;
    @(posedge clk_sys);
    cal_done <= 1'b0;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    if (v != 9'h000 && !v[8])
      scale_r = v[7:0];
    #1 chk("scale after cal", reg_rdata, {8'h00, scale_r});
    rd(`FEA_OFS_CAL_STATUS);
    if (v[8])
      chk("cal status", rd_val, {7'h40, v});
  endtask

  // walk one whole period from count zero
  task automatic run_period(input int p, input logic fpe, input logic a, input logic [7:0] cf, input logic [7:0] pf);
    logic on;
    logic pv;
    int   n;
    n = 0;
    repeat (3) @(posedge clk_sys);
    #1;
    pv = pwm_out;
    // Wait for a rise, so the walk starts at count zero
    while (!(pwm_out === 1'b1 && pv === 1'b0) && n < 64)
    begin
      pv = pwm_out;
      @(posedge clk_sys);
      #1 n++;
    end
    for (int k = 0; k <= p; k++)
    begin
      on = (k >= 3) && !(fpe && k + 3 > p);
      chk("fine active", {15'h0000, fine_out.active}, {15'h0000, on});
      if (on)
      begin
        chk("duty steps", {8'h00, fine_out.duty_steps}, {8'h00, conv(cf, scale_r, a)});
        if (fpe)
          chk("period steps", {8'h00, fine_out.period_steps}, {8'h00, conv(pf, scale_r, a)});
      end
      @(posedge clk_sys);
      #1;
    end
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    // reset values, write-only and unmapped reads
    for (int i = 0; i < 7; i++)
    begin
      rd(rst_a[i]);
      chk("reset value", rd_val, rst_v[i]);
    end
    // protected scale writes; a zero write is refused
    wr(`FEA_OFS_SCALE, 16'h0040);
    rd(`FEA_OFS_SCALE);
    chk("locked scale", rd_val, 16'h0000);
    wr(`FEA_OFS_UNLOCK, `FEA_UNLOCK_KEY);
    wr(`FEA_OFS_SCALE, 16'h01C3);
    rd(`FEA_OFS_SCALE);
    chk("scale low byte", rd_val, 16'h00C3);
    scale_r = 8'hC3;
    wr(`FEA_OFS_SCALE, 16'h0000);
    rd(`FEA_OFS_SCALE);
    chk("scale zero write", rd_val, 16'h00C3);
    // random results with error and zero corners
    for (int i = 0; i < 6; i++)
    begin
      lfsr_r = lfsr_next(lfsr_r);
      cal_rd((i == 2) ? 9'h1F0 : (i == 4) ? 9'h000 : {1'b0, lfsr_r[7:0] | 8'h01});
    end
    // Interrupt: masked, raised, then cleared
    chk("irq masked", {15'h0000, irq}, 16'h0000);
    wr(`FEA_OFS_INT_ENABLE, 16'h0004);
    #1 chk("irq raised", {15'h0000, irq}, 16'h0001);
    wr(`FEA_OFS_INT_CLEAR, 16'h0004);
    #1 chk("irq cleared", {15'h0000, irq}, 16'h0000);
    // guards and conversion; fine period only with auto
    wr(`FEA_OFS_PRD_COARSE, 16'h000B);
    wr(`FEA_OFS_COMPARE_A_COARSE_COARSE, 16'h0005);
    for (int i = 0; i < 4; i++)
    begin
      lfsr_r = lfsr_next(lfsr_r);
      au = !i[0] | i[1];
      // manual mode writes ready-made step counts
      wr(`FEA_OFS_COMPARE_A_COARSE_FINE, {lfsr_r[7:0], 8'h00});
      wr(`FEA_OFS_PRD_FINE, {lfsr_r[15:8], 8'h00});
      wr(`FEA_OFS_PRD_CTRL, {15'h0000, i[1]});
      wr(`FEA_OFS_CONFIG, {14'h0000, au, 1'b1});
      run_period(11, i[1], au, lfsr_r[7:0], lfsr_r[15:8]);
    end
    // phase loads on input, compare and forced sync
    wr(`FEA_OFS_PRD_CTRL, 16'h0004);
    for (int i = 0; i < 3; i++)
    begin
      lfsr_r = lfsr_next(lfsr_r);
      au = i[0];
      wr(`FEA_OFS_CONFIG, {14'h0000, au, 1'b1});
      wr(`FEA_OFS_PHASE_FINE, {lfsr_r[7:0], 8'h00});
      @(posedge clk_sys);
      sync_in      <= (i == 0);
      compare_sync <= (i == 1);
      reg_wr       <= (i == 2);
      reg_addr     <= `FEA_OFS_FORCE_SYNC;
      reg_wdata    <= 16'h0001;
      @(posedge clk_sys);
      sync_in      <= 1'b0;
      compare_sync <= 1'b0;
      reg_wr       <= 1'b0;
      @(posedge clk_sys);
      #1 chk("phase steps", {8'h00, fine_out.phase_steps}, {8'h00, conv(lfsr_r[7:0], scale_r, au)});
    end
    end_of_test();
  end

  // Watchdog far beyond the few hundred cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    end_of_test();
  end
endmodule
`default_nettype wire
